// *** rtl/dis_serializer.sv ***
// Eight-channel debounced input serializer with chained serial readout
//
// Contract
// - Eight channels captured, shifted out serially.
// - New level accepted after full quiet interval.
// - Select pins pick 3 ms, 1 ms, bypass.
// - Bypass selection passes changes without delay.
// - Unconnected select pins read as high.
// - Strobe low copies filtered levels into register.
// - Strobe high blocks parallel levels from register.
// - Shift on serial clock rise, gate low.
// - Stages move toward output; first takes input.
// - With strobe high, gate high holds register regardless of clock.
// - After eight shifts output follows serial input.
// - First trip point drives flag low.
// - Second trip point floats all outputs.
// - Weak pulldown keeps floated flag low.
// - Strobe low captures, strobe high shifts.
`timescale 1ns/100ps
`include "dis_params.svh"
module dis_serializer
    import dis_pkg::*;
#(
    parameter int                    TICK_CYCLES = `DIS_TICK_CYC,
    parameter logic [`DIS_CNT_W-1:0] SHORT_TICKS = `DIS_CNT_W'(`DIS_DB_SHORT_TICK),
    parameter logic [`DIS_CNT_W-1:0] LONG_TICKS  = `DIS_CNT_W'(`DIS_DB_LONG_TICK)
)(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] field_channel_inputs,
    input  wire logic       filter_select0,
    input  wire logic       filter_select1,
    input  wire logic       capture_strobe_n,
    input  wire logic       clock_gate_n,
    input  wire logic       serial_clk,
    input  wire logic       chain_serial_in,
    input  wire logic       temp_trip1,
    input  wire logic       temp_trip2,
    output logic            chain_serial_out,
    output logic            chain_serial_out_oe_n,
    output logic            overtemp_flag_n,
    output logic            overtemp_flag_oe_n,
    output logic            overtemp_pulldown_en
);

    typedef struct packed {
        logic [1:0][7:0] fld_sy;
        logic [1:0]      sel0_sy;
        logic [1:0]      sel1_sy;
        logic [1:0]      cap_sy;
        logic [1:0]      ce_sy;
        logic [1:0]      sck_sy;
        logic [1:0]      sin_sy;
        logic [1:0]      t1_sy;
        logic [1:0]      t2_sy;
        logic            sck_d;
        dis_mode_e       mode;
        dis_flt_e        flt;
        dis_byte_t       sr;
        logic            sout;
        logic            sout_oe_n;
        logic            hot_n;
        logic            hot_oe_n;
        logic            pd_en;
    } dis_top_s;

    dis_top_s   q;
    dis_top_s   d;
    logic [1:0] rst_sy_r;
    logic       rst_int_n;
    logic       tick;
    logic       cap_n;
    logic       ce_n;
    logic       sin;
    logic       sck_rise;
    logic       shift_en;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sy_r <= 2'h0;
        else
            rst_sy_r <= {rst_sy_r[0], 1'b1};
    end

    assign rst_int_n = rst_sy_r[1];

    // Time base for the filter counters
    dis_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .rst_n   (rst_int_n),
        .tick    (tick)
    );

    dis_db_if u_db ();

    // Filters see only second-stage synchronised levels
    assign u_db.raw  = q.fld_sy[1];
    assign u_db.tick = tick;
    assign u_db.mode = q.flt;

    // eight channels filtered in one bank
    dis_filter #(
        .SHORT_TICKS (SHORT_TICKS),
        .LONG_TICKS  (LONG_TICKS)
    ) u_filt (
        .sys_clk (sys_clk),
        .rst_n   (rst_int_n),
        .db      (u_db.filt)
    );

    // Second synchroniser stages feed all logic below
    assign cap_n    = q.cap_sy[1];
    assign ce_n     = q.ce_sy[1];
    assign sin      = q.sin_sy[1];
    assign sck_rise = q.sck_sy[1] & ~q.sck_d;

    // shift needs rise, strobe high, gate low
    assign shift_en = sck_rise & cap_n & ~ce_n;

    // Next-state logic for the whole core
    always_comb
    begin
        d = q;

        // Two-flop synchronisers; the first stage feeds only the second
        d.fld_sy = {q.fld_sy[0], field_channel_inputs};
        d.sel0_sy = {q.sel0_sy[0], filter_select0};
        d.sel1_sy = {q.sel1_sy[0], filter_select1};
        d.cap_sy  = {q.cap_sy[0], capture_strobe_n};
        d.ce_sy  = {q.ce_sy[0], clock_gate_n};
        d.sck_sy = {q.sck_sy[0], serial_clk};
        d.sin_sy = {q.sin_sy[0], chain_serial_in};
        d.t1_sy  = {q.t1_sy[0], temp_trip1};
        d.t2_sy  = {q.t2_sy[0], temp_trip2};
        d.sck_d  = q.sck_sy[1];

        // pad pull-ups make open read as one
        case ({q.sel1_sy[1], q.sel0_sy[1]})
            2'h3:    d.flt = DIS_FLT_LONG;
            2'h2:    d.flt = DIS_FLT_SHORT;
            2'h1:    d.flt = DIS_FLT_BYPASS;
            default: d.flt = DIS_FLT_RSVD;
        endcase

        case (q.mode)
            DIS_MODE_CAPTURE:
            begin
                if (cap_n)
                    d.mode = DIS_MODE_SHIFT;
            end
            DIS_MODE_SHIFT:
            begin
                if (!cap_n)
                    d.mode = DIS_MODE_CAPTURE;
            end
            default: d.mode = DIS_MODE_SHIFT;
        endcase

        // strobe low copies, ignores clock and gate
        // channel i lands in stage i
        if (!cap_n)
            d.sr = u_db.clean;
        // shift toward output, serial input enters
        // input reaches output after eight shifts
        else if (shift_en)
            d.sr = {q.sr[6:0], sin};
        // gate high or no rise holds register
        else
            d.sr = q.sr;

        // output mirrors last stage at all times
        d.sout = d.sr[7];

        d.hot_n = ~q.t1_sy[1];

        d.sout_oe_n = q.t2_sy[1];
        d.hot_oe_n = q.t2_sy[1];
        d.pd_en    = q.t2_sy[1];
    end

    // Single state register; the outputs come straight from it
    always_ff @(posedge sys_clk or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            q         <= '0;
            q.mode    <= DIS_MODE_SHIFT;
            q.flt     <= DIS_FLT_LONG;
            // Syncs start at idle pin levels; zero would fake a load at release
            q.sel0_sy <= `DIS_SYNC_IDLE;
            q.sel1_sy <= `DIS_SYNC_IDLE;
            q.cap_sy  <= `DIS_SYNC_IDLE;
            q.ce_sy   <= `DIS_SYNC_IDLE;
            q.sin_sy  <= `DIS_SYNC_IDLE;
            q.sr      <= `DIS_SR_RST;
            q.sout    <= 1'b1;
            q.hot_n   <= 1'b1;
        end
        else
            q <= d;
    end

    assign chain_serial_out      = q.sout;
    assign chain_serial_out_oe_n = q.sout_oe_n;
    assign overtemp_flag_n       = q.hot_n;
    assign overtemp_flag_oe_n    = q.hot_oe_n;
    assign overtemp_pulldown_en  = q.pd_en;

    // Capture mode loads filtered levels
    load_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        !cap_n |=> q.sr == $past(u_db.clean))
        else $error("register did not take filtered levels while strobe low");

    // Shift step moves each stage by one
    shift_step_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        shift_en |=> q.sr == {$past(q.sr[6:0]), $past(sin)})
        else $error("shift did not move stages toward output");

    // Shift enable tied to a rising serial clock
    shift_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        cap_n && !ce_n && q.sck_sy[1] && !q.sck_d |=> q.sr == {$past(q.sr[6:0]), $past(sin)})
        else $error("gated rising edge did not shift register");

    // No parallel entry while strobe high
    no_load_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        cap_n && !shift_en |=> $stable(q.sr))
        else $error("register changed in shift mode without a shift");

    // Gate high freezes register over clock edges
    gate_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        cap_n && ce_n ##1 cap_n && ce_n |=> $stable(q.sr))
        else $error("register moved while clock gate high");

    // Output tracks stage seven one cycle after a shift
    sout_track_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        shift_en |=> chain_serial_out == $past(q.sr[6]))
        else $error("serial output does not show last stage");

    // Flag low at first trip
    hot_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        q.t1_sy[1] |=> !overtemp_flag_n)
        else $error("overtemperature flag not driven low");

    // Second trip floats outputs with pulldown on
    shutdown_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        q.t2_sy[1] |=> chain_serial_out_oe_n && overtemp_flag_oe_n && overtemp_pulldown_en)
        else $error("outputs not released at shutdown trip");

    // Mode follows strobe with one cycle lag
    mode_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        !cap_n |=> q.mode == DIS_MODE_CAPTURE)
        else $error("capture mode not entered with strobe low");

    // Strobe high returns to shift mode
    mode_shift_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        cap_n |=> q.mode == DIS_MODE_SHIFT)
        else $error("shift mode not entered with strobe high");

    // Both selects high pick the long interval
    sel_long_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        q.sel1_sy[1] && q.sel0_sy[1] |=> q.flt == DIS_FLT_LONG)
        else $error("select decode missed long interval");

    // Select one high, select zero low pick the short interval
    sel_short_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        q.sel1_sy[1] && !q.sel0_sy[1] |=> q.flt == DIS_FLT_SHORT)
        else $error("select decode missed short interval");

    // Select one low, select zero high bypass the filter
    sel_bypass_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        !q.sel1_sy[1] && q.sel0_sy[1] |=> q.flt == DIS_FLT_BYPASS)
        else $error("select decode missed bypass");

    // First captured bit shows on the output right after a load
    load_out_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        !cap_n |=> chain_serial_out == $past(u_db.clean[7]))
        else $error("serial output missed channel seven after load");

    // No rising serial clock, no shift
    no_rise_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        cap_n && !ce_n && !sck_rise |=> $stable(q.sr))
        else $error("register shifted without a serial clock rise");

    // Flag released once below the first trip
    flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        !q.t1_sy[1] |=> overtemp_flag_n)
        else $error("overtemperature flag low without a trip");

    // Outputs stay driven below the second trip
    outputs_driven_a: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
        !q.t2_sy[1] |=> !chain_serial_out_oe_n && !overtemp_flag_oe_n && !overtemp_pulldown_en)
        else $error("outputs released without shutdown trip");

endmodule : dis_serializer

// *** rtl/dis_params.svh ***
// Constants for the debounced input serializer: timing, widths, reset values
`ifndef DIS_PARAMS_SVH
`define DIS_PARAMS_SVH

// Channel count and stage widths
`define DIS_CH_NUM        8
`define DIS_CNT_W         12
`define DIS_DIV_W         8

// System clock rate in MHz (5 ns period)
`define DIS_SYS_CLK_MHZ   200

// Time base tick: 1 us, derived into system clock cycles
`define DIS_TICK_US       1
`define DIS_TICK_CYC      ((`DIS_TICK_US) * (`DIS_SYS_CLK_MHZ))

// Debounce intervals in ms, and as counts of time base ticks
`define DIS_DB_SHORT_MS   1
`define DIS_DB_LONG_MS    3
`define DIS_DB_SHORT_TICK ((`DIS_DB_SHORT_MS) * 1000 / (`DIS_TICK_US))
`define DIS_DB_LONG_TICK  ((`DIS_DB_LONG_MS) * 1000 / (`DIS_TICK_US))

// Reset values
`define DIS_SR_RST        8'hff
`define DIS_CLEAN_RST     8'h00
`define DIS_SYNC_IDLE     2'h3

`endif

// *** rtl/dis_pkg.sv ***
// Types shared by the debounced input serializer modules
package dis_pkg;

    // Filter interval decoded from the two select pins
    typedef enum logic [3:0] {
        DIS_FLT_LONG   = 4'h1,
        DIS_FLT_SHORT  = 4'h2,
        DIS_FLT_BYPASS = 4'h4,
        DIS_FLT_RSVD   = 4'h8
    } dis_flt_e;

    // Operating mode chosen by the capture strobe
    typedef enum logic [1:0] {
        DIS_MODE_CAPTURE = 2'h1,
        DIS_MODE_SHIFT   = 2'h2
    } dis_mode_e;

    typedef logic [7:0] dis_byte_t;

endpackage : dis_pkg

// *** rtl/dis_db_if.sv ***
// Link between the serializer core and its debounce filter bank
`timescale 1ns/100ps
interface dis_db_if;
    import dis_pkg::*;
    dis_byte_t raw;
    dis_byte_t clean;
    logic      tick;
    dis_flt_e  mode;

    modport core (output raw, output tick, output mode, input clean);
    modport filt (input raw, input tick, input mode, output clean);
endinterface : dis_db_if

// *** rtl/dis_tick_gen.sv ***
// Time base divider giving a one-cycle tick for the debounce counters
`timescale 1ns/100ps
`include "dis_params.svh"
module dis_tick_gen
    import dis_pkg::*;
#(
    parameter int TICK_CYCLES = `DIS_TICK_CYC
)(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    output logic      tick
);

    typedef struct packed {
        logic [`DIS_DIV_W-1:0] cnt;
        logic                  tick;
    } dis_tick_s;

    dis_tick_s q;
    dis_tick_s d;

    // Wrap at TICK_CYCLES-1, pulse on the wrap
    always_comb
    begin
        d      = q;
        d.tick = 1'b0;
        if (q.cnt == `DIS_DIV_W'(TICK_CYCLES - 1))
        begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + `DIS_DIV_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    assign tick = q.tick;

    tick_single_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        q.tick |=> !q.tick) else $error("time base tick lasted two cycles");

endmodule : dis_tick_gen

// *** rtl/dis_filter.sv ***
// Bank of eight debounce filters with a shared interval counter width
`timescale 1ns/100ps
`include "dis_params.svh"
module dis_filter
    import dis_pkg::*;
#(
    parameter logic [`DIS_CNT_W-1:0] SHORT_TICKS = `DIS_CNT_W'(`DIS_DB_SHORT_TICK),
    parameter logic [`DIS_CNT_W-1:0] LONG_TICKS  = `DIS_CNT_W'(`DIS_DB_LONG_TICK)
)(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    dis_db_if.filt    db
);

    typedef struct packed {
        logic [`DIS_CH_NUM-1:0][`DIS_CNT_W-1:0] cnt;
        dis_byte_t                              clean;
    } dis_filt_s;

    dis_filt_s              q;
    dis_filt_s              d;
    logic [`DIS_CNT_W-1:0]  limit;

    // Terminal count for the selected interval
    // parameterised terminal counts
    always_comb
    begin
        limit = LONG_TICKS;
        if (db.mode == DIS_FLT_SHORT)
            limit = SHORT_TICKS;
    end

    // Per channel: restart on any change back, accept after a full quiet interval
    always_comb
    begin
        d = q;
        for (int i = 0; i < `DIS_CH_NUM; i++)
        begin
            if (db.raw[i] == q.clean[i])
                d.cnt[i] = '0;
            else if (db.mode == DIS_FLT_BYPASS)
            begin
                d.clean[i] = db.raw[i];
                d.cnt[i]   = '0;
            end
            // Reserved selection freezes the filtered levels
            else if (db.mode == DIS_FLT_RSVD)
                d.cnt[i] = '0;
            else if (db.tick)
            begin
                if (q.cnt[i] + `DIS_CNT_W'(1) >= limit)
                begin
                    d.clean[i] = db.raw[i];
                    d.cnt[i]   = '0;
                end
                else
                    d.cnt[i] = q.cnt[i] + `DIS_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q       <= '0;
            q.clean <= `DIS_CLEAN_RST;
        end
        else
            q <= d;
    end

    assign db.clean = q.clean;

    bypass_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        db.mode == DIS_FLT_BYPASS |=> q.clean == $past(db.raw))
        else $error("bypass filter did not pass input through");

    // outside bypass, channel 0 changes only at terminal count
    filter_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($past(db.mode) != DIS_FLT_BYPASS) && $changed(q.clean[0])
        |-> $past(db.tick) && ($past(q.cnt[0]) + `DIS_CNT_W'(1) >= $past(limit)))
        else $error("filtered level changed before interval elapsed");

endmodule : dis_filter

// *** test/dis_host_model.sv ***
// Host controller model that loads and clocks out the serializer
`timescale 1ns/100ps
module dis_host_model (
    input  wire logic sys_clk,
    input  wire logic chain_serial_out,
    output logic      capture_strobe_n,
    output logic      clock_gate_n,
    output logic      serial_clk,
    output logic      chain_serial_in
);
    // Idle link: clock parked low, cascade line pulled high
    initial
    begin
        capture_strobe_n = 1'b1;
        clock_gate_n     = 1'b1;
        serial_clk       = 1'b0;
        chain_serial_in  = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_clk

    // One 125 ns serial clock period, high phase first
    task automatic pulse();
        serial_clk <= 1'b1;
        wait_clk(12);
        serial_clk <= 1'b0;
        wait_clk(13);
    endtask : pulse

    task automatic load(input bit clocked);
        capture_strobe_n <= 1'b0;
        wait_clk(4);
        if (clocked)
        begin
            clock_gate_n <= 1'b0;
            pulse();
            clock_gate_n <= 1'b1;
            wait_clk(4);
        end
        capture_strobe_n <= 1'b1;
        wait_clk(4);
    endtask : load

    task automatic read_bits(input int n, input logic [15:0] feed, input int pause_at,
                             output logic [15:0] got);
        got = 16'hffff;
        clock_gate_n <= 1'b0;
        wait_clk(4);
        for (int i = 0; i < n; i++)
        begin
            got[i] = chain_serial_out;
            // Gate held high while the clock keeps running
            if (i == pause_at)
            begin
                clock_gate_n <= 1'b1;
                wait_clk(4);
                pulse();
                pulse();
                clock_gate_n <= 1'b0;
                wait_clk(4);
            end
            chain_serial_in <= feed[i];
            wait_clk(4);
            pulse();
        end
        clock_gate_n    <= 1'b1;
        chain_serial_in <= 1'b1;
        wait_clk(4);
    endtask : read_bits
endmodule : dis_host_model

// *** test/tb_top.sv ***
// Self-checking bench for the debounced input serializer
`timescale 1ns/100ps
module tb_top;
    import dis_pkg::*;
    logic        sys_clk;
    logic        rst_n;
    logic [7:0]  field_in;
    logic        sel0;
    logic        sel1;
    logic        trip1;
    logic        trip2;
    logic        strobe_n;
    logic        gate_n;
    logic        sclk;
    logic        feed_in;
    logic        sout;
    logic        sout_oe_n;
    logic        flag_n;
    logic        flag_oe_n;
    logic        pd_en;
    wire         sout_wire;
    wire         flag_wire;
    int          miscompares;
    int          checks;
    int          clean_m;
    logic [31:0] lfsr_r;

    // Pin levels seen outside the device, pulldown included
    assign sout_wire = sout_oe_n ? 1'bz : sout;
    assign flag_wire = !flag_oe_n ? flag_n : (pd_en ? 1'b0 : 1'bz);

    dis_serializer #(
        .TICK_CYCLES (4),
        .SHORT_TICKS (12'h003),
        .LONG_TICKS  (12'h006)
    ) i_dis_serializer (
        .sys_clk              (sys_clk),
        .rst_n                (rst_n),
        .field_channel_inputs (field_in),
        .filter_select0       (sel0),
        .filter_select1       (sel1),
        .capture_strobe_n     (strobe_n),
        .clock_gate_n         (gate_n),
        .serial_clk           (sclk),
        .chain_serial_in      (feed_in),
        .temp_trip1           (trip1),
        .temp_trip2           (trip2),
        .chain_serial_out     (sout),
        .chain_serial_out_oe_n(sout_oe_n),
        .overtemp_flag_n      (flag_n),
        .overtemp_flag_oe_n   (flag_oe_n),
        .overtemp_pulldown_en (pd_en)
    );

    dis_host_model i_dis_host_model (
        .sys_clk         (sys_clk),
        .chain_serial_out(sout_wire),
        .capture_strobe_n(strobe_n),
        .clock_gate_n    (gate_n),
        .serial_clk      (sclk),
        .chain_serial_in (feed_in)
    );

    // Free-running 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;

    function automatic logic [31:0] lfsr();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r;
    endfunction : lfsr

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // Load, scramble the pins, read n bits and compare with the model
    task automatic frame(input int n, input int pause_at, input bit clocked);
        logic [15:0] feed;
        logic [15:0] got;
        int          q[$];
        feed = 16'(lfsr());
        i_dis_host_model.load(clocked);
        field_in <= 8'(lfsr());
        i_dis_host_model.read_bits(n, feed, pause_at, got);
        for (int i = 0; i < 8; i++)
            q.push_back((clean_m >> (7 - i)) & 1);
        for (int i = 8; i < n; i++)
            q.push_back(int'(feed[i-8]));
        check(16'(got[0]), 16'((clean_m >> 7) & 1));
        for (int i = 0; i < n; i++)
            check(16'(got[i]), 16'(q.pop_front()));
    endtask : frame

    task automatic set_base(input logic [7:0] base);
        @(posedge sys_clk);
        sel1     <= 1'b0;
        sel0     <= 1'b1;
        field_in <= base;
        repeat (12) @(posedge sys_clk);
        clean_m = int'(base);
    endtask : set_base

    // Watchdog far beyond the expected run length
    initial
    begin
        #300000;
        miscompares++;
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        logic [7:0] base;
        int         len   [5];
        logic [1:0] mode  [5];
        bit         taken [5];
        len         = '{4, 28, 16, 44, 60};
        mode        = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
        taken       = '{0, 1, 0, 1, 0};
        sys_clk     = 1'b0;
        rst_n       = 1'b0;
        field_in    = 8'h00;
        sel0        = 1'b1;
        sel1        = 1'b1;
        trip1       = 1'b0;
        trip2       = 1'b0;
        miscompares = 0;
        checks      = 0;
        lfsr_r      = 32'hab1f;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check(16'(sout_wire), 16'h0001);
        // Bypass frames: chained length, gate pause, clocks during load
        for (int k = 0; k < 4; k++)
        begin
            set_base(8'(lfsr()));
            frame(k < 2 ? 16 : 8, k == 1 ? 3 : -1, k == 2);
        end
        // Glitches against each interval and the reserved setting
        for (int k = 0; k < 5; k++)
        begin
            base = 8'(lfsr());
            set_base(base);
            sel1 <= mode[k][1];
            sel0 <= mode[k][0];
            repeat (6) @(posedge sys_clk);
            field_in <= ~base;
            repeat (len[k]) @(posedge sys_clk);
            field_in <= base;
            clean_m = taken[k] ? int'(~base) : int'(base);
            frame(8, -1, 0);
        end
        // Thermal trip points
        trip1 <= 1'b1;
        repeat (5) @(posedge sys_clk);
        check(16'(flag_wire), 16'h0000);
        check(16'(sout_oe_n), 16'h0000);
        trip2 <= 1'b1;
        repeat (5) @(posedge sys_clk);
        check(16'({sout_oe_n, flag_oe_n}), 16'h0003);
        check(16'(flag_wire), 16'h0000);
        trip1 <= 1'b0;
        trip2 <= 1'b0;
        repeat (5) @(posedge sys_clk);
        check(16'(flag_wire), 16'h0001);
        report_and_stop();
    end
endmodule : tb_top
